// ===== cascaded_timer_defs.svh
// register offsets, field positions, reset values and clock taps of the cascaded timer
`ifndef CASCADED_TIMER_DEFS_SVH
`define CASCADED_TIMER_DEFS_SVH
`define ADDR_W 3
`define OFS_LOWER_CTRL 3'h0
`define OFS_UPPER_CTRL 3'h1
`define OFS_CMP_LO 3'h2
`define OFS_CMP_HI 3'h3
`define OFS_DUTY_LO 3'h4
`define OFS_DUTY_HI 3'h5
`define OFS_CNT_LO 3'h6
`define OFS_CNT_HI 3'h7
// lower control: clock select [2:0]
`define CKSEL_LSB 0
`define CKSEL_MSB 2
// upper control: mode [1:0], divider chain select 2, run 3, flip-flop preset 7
`define MODE_LSB 0
`define MODE_MSB 1
`define DVSEL_BIT 2
`define RUN_BIT 3
`define FFINIT_BIT 7
`define CTRL_RST 8'h00
`define CMP_RST 16'hFFFF
`define DUTY_RST 16'h0000
// clock select codes
`define CK_SLOW_TAP 3'h0
`define CK_DIV7 3'h1
`define CK_DIV5 3'h2
`define CK_DIV3 3'h3
`define CK_LOWFREQ 3'h4
`define CK_DIV1 3'h5
`define CK_FULL 3'h6
`define CK_EVENT 3'h7
// prescaler tap positions in a free divider of the system clock
`define PRE_W 11
`define TAP_DIV11 10
`define TAP_DIV7 6
`define TAP_DIV5 4
`define TAP_DIV3 2
`define TAP_DIV1 0
`endif

// ===== cascaded_timer_pkg.sv
// types of the cascaded timer
package cascaded_timer_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_PWM = 2'h2,
    MODE_RSVD = 2'h3
  } mode_e;
endpackage : cascaded_timer_pkg

// ===== cascaded_16bit_timer_pwm.sv
// one 16-bit counter, read as two bytes, forming a 16-bit timer, event counter and pwm
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "cascaded_timer_defs.svh"

// Behaviour
// - timer mode counts prescaled ticks, sixteen bits
// - run bit starts and stops counting
// - compare match interrupts and clears counter
// - compare value takes effect immediately
// - event mode counts event falling edges
// - select code seven picks event input outside timer mode
// - prescaler taps selectable by field
// - pwm adds full and half clock taps
// - pwm duty match below 0xFFFF toggles, keeps counting
// - pwm overflow toggles unless duty matches too, clears, interrupts
// - preset bit loads flip-flop, reset clears
// - output pin is inverted flip-flop
// - duty double-buffered, loads at interrupt
// - duty read returns active stage
// - stop holds output level
module cascaded_16bit_timer_pwm (
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic [`ADDR_W-1:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after read strobe
  input wire logic low_freq_clock_i, // slow clock level from pin
  input wire logic event_input_pin_i, // external event input
  output logic timer_output_pin_o, // inverted output flip-flop
  output logic combined_timer_irq_o // one-cycle interrupt pulse
);

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  logic [7:0] lower_timer_control_r;
  logic [7:0] upper_timer_control_r;
  logic [7:0] compare_low_byte_r;
  logic [7:0] compare_high_byte_r;
  logic [7:0] duty_low_byte_r; // buffer stage, low
  logic [7:0] duty_high_byte_r; // buffer stage, high
  logic [15:0] duty_active_r;
  logic [15:0] count_r;
  logic output_flipflop_r;
  logic [`PRE_W-1:0] pre_r;
  logic [1:0] ev_sync_r;
  logic ev_prev_r;
  logic [1:0] fs_sync_r;
  logic fs_prev_r;
  logic [2:0] fs_div_r;
  logic irq_r;

  cascaded_timer_pkg::mode_e mode;
  logic run;
  logic [2:0] cksel;
  logic [15:0] compare;
  logic tick;
  logic fs_tick;
  logic fs8_tick;
  logic cmp_hit;
  logic ovf_hit;
  logic duty_hit;
  logic [15:0] count_nxt;

  // reset words split into bytes here; a literal cannot be part-selected
  localparam logic [15:0] CMP_INIT = `CMP_RST;
  localparam logic [15:0] DUTY_INIT = `DUTY_RST;

  // rising edge of a bit in the free prescaler
  function automatic logic tap_edge(input logic [`PRE_W-1:0] p, input int b);
    logic [`PRE_W-1:0] n;
    n = p + `PRE_W'(1);
    return n[b] & ~p[b];
  endfunction : tap_edge

  // ---------------------------------------------
  // control decode
  // ---------------------------------------------
  assign mode = cascaded_timer_pkg::mode_e'(upper_timer_control_r[`MODE_MSB:`MODE_LSB]);
  assign run = upper_timer_control_r[`RUN_BIT];
  assign cksel = lower_timer_control_r[`CKSEL_MSB:`CKSEL_LSB];
  assign compare = {compare_high_byte_r, compare_low_byte_r};

  // register writes; compare has no buffer so it acts at once
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lower_timer_control_r <= `CTRL_RST;
      upper_timer_control_r <= `CTRL_RST;
      compare_low_byte_r <= CMP_INIT[7:0];
      compare_high_byte_r <= CMP_INIT[15:8];
      duty_low_byte_r <= DUTY_INIT[7:0];
      duty_high_byte_r <= DUTY_INIT[15:8];
    end else if (wr_i) begin
      case (addr_i)
        `OFS_LOWER_CTRL: lower_timer_control_r <= wdata_i;
        `OFS_UPPER_CTRL: upper_timer_control_r <= wdata_i;
        `OFS_CMP_LO: compare_low_byte_r <= wdata_i;
        `OFS_CMP_HI: compare_high_byte_r <= wdata_i;
        `OFS_DUTY_LO: duty_low_byte_r <= wdata_i;
        `OFS_DUTY_HI: duty_high_byte_r <= wdata_i;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------
  // clock sources
  // ---------------------------------------------
  // free divider standing in for the high-frequency prescaler chain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + `PRE_W'(1);
    end
  end

  // pin inputs pass two flip-flops before any edge detection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ev_sync_r <= 2'b11;
      ev_prev_r <= 1'b1;
      fs_sync_r <= 2'b00;
      fs_prev_r <= 1'b0;
      fs_div_r <= 3'h0;
    end else begin
      ev_sync_r <= {ev_sync_r[0], event_input_pin_i};
      ev_prev_r <= ev_sync_r[1];
      fs_sync_r <= {fs_sync_r[0], low_freq_clock_i};
      fs_prev_r <= fs_sync_r[1];
      if (fs_tick) begin
        fs_div_r <= fs_div_r + 3'h1;
      end
    end
  end

  assign fs_tick = fs_sync_r[1] & ~fs_prev_r;
  assign fs8_tick = fs_tick & (fs_div_r == 3'h7);

  // tick select; the full and half taps exist only in pwm mode
  always_comb begin
    tick = 1'b0;
    case (cksel)
      `CK_SLOW_TAP: tick = upper_timer_control_r[`DVSEL_BIT] ? fs8_tick
                           : tap_edge(pre_r, `TAP_DIV11);
      `CK_DIV7: tick = tap_edge(pre_r, `TAP_DIV7);
      `CK_DIV5: tick = tap_edge(pre_r, `TAP_DIV5);
      `CK_DIV3: tick = tap_edge(pre_r, `TAP_DIV3);
      `CK_LOWFREQ: tick = fs_tick;
      `CK_DIV1: tick = (mode == cascaded_timer_pkg::MODE_PWM)
                       & tap_edge(pre_r, `TAP_DIV1);
      `CK_FULL: tick = (mode == cascaded_timer_pkg::MODE_PWM);
      `CK_EVENT: tick = (mode != cascaded_timer_pkg::MODE_TIMER)
                        & ev_prev_r & ~ev_sync_r[1];
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------
  // counter
  // ---------------------------------------------
  assign cmp_hit = run & tick & (mode != cascaded_timer_pkg::MODE_PWM)
                   & (mode != cascaded_timer_pkg::MODE_RSVD) & (count_r == compare);
  assign ovf_hit = run & tick & (mode == cascaded_timer_pkg::MODE_PWM) & (&count_r);
  assign duty_hit = run & tick & (mode == cascaded_timer_pkg::MODE_PWM)
                    & (count_r == duty_active_r);

  // one 16-bit up-counter, low byte from lower half, high byte from upper
  always_comb begin
    count_nxt = count_r;
    if (cmp_hit || ovf_hit) begin
      count_nxt = 16'h0000;
    end else if (run && tick && mode != cascaded_timer_pkg::MODE_RSVD) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_r <= 16'h0000;
    end else if (!run) begin
      count_r <= 16'h0000; // stopped counter restarts from zero
    end else begin
      count_r <= count_nxt;
    end
  end

  // interrupt pulse on compare clear or pwm overflow
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= cmp_hit | ovf_hit;
    end
  end

  assign combined_timer_irq_o = irq_r;

  // active duty: loaded at interrupt while running, at once while stopped
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      duty_active_r <= `DUTY_RST;
    end else if (!run || ovf_hit) begin
      duty_active_r <= {duty_high_byte_r, duty_low_byte_r};
    end
  end

  // ---------------------------------------------
  // output flip-flop
  // ---------------------------------------------
  // preset only while stopped and not in the stopping write, so the pin holds
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      output_flipflop_r <= 1'b0;
    end else if (wr_i && addr_i == `OFS_UPPER_CTRL && !run && !wdata_i[`RUN_BIT]) begin
      output_flipflop_r <= wdata_i[`FFINIT_BIT];
    end else if (wr_i && addr_i == `OFS_UPPER_CTRL && !run) begin
      output_flipflop_r <= wdata_i[`FFINIT_BIT]; // preset at start
    end else if (duty_hit ^ ovf_hit) begin
      output_flipflop_r <= ~output_flipflop_r;
    end
  end

  assign timer_output_pin_o = ~output_flipflop_r;

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_LOWER_CTRL: rdata_o <= lower_timer_control_r;
        `OFS_UPPER_CTRL: rdata_o <= upper_timer_control_r;
        `OFS_CMP_LO: rdata_o <= compare_low_byte_r;
        `OFS_CMP_HI: rdata_o <= compare_high_byte_r;
        `OFS_DUTY_LO: rdata_o <= duty_active_r[7:0];
        `OFS_DUTY_HI: rdata_o <= duty_active_r[15:8];
        `OFS_CNT_LO: rdata_o <= count_r[7:0];
        `OFS_CNT_HI: rdata_o <= count_r[15:8];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  cmp_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cmp_hit |=> (count_r == 16'h0000) && combined_timer_irq_o)
    else $error("compare match did not clear and interrupt");

  stop_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!run && !$past(run)) |-> (count_r == 16'h0000))
    else $error("counter moved while stopped");

  pwm_ovf_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ovf_hit && !duty_hit && !wr_i) |=> (output_flipflop_r != $past(output_flipflop_r))
    && (count_r == 16'h0000) && combined_timer_irq_o)
    else $error("pwm overflow did not toggle, clear and interrupt");

  duty_tog_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (duty_hit && !ovf_hit && !wr_i) |=> (output_flipflop_r != $past(output_flipflop_r))
    && (count_r == $past(count_r) + 16'h0001))
    else $error("duty match did not toggle or counter cleared");

  pin_inv_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    timer_output_pin_o == !output_flipflop_r)
    else $error("output pin not inverse of flip-flop");

  ff_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (mode != cascaded_timer_pkg::MODE_PWM && run && $past(run)) |-> $stable(output_flipflop_r))
    else $error("flip-flop changed outside pwm");

  duty_buf_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (run && !ovf_hit) |=> $stable(duty_active_r))
    else $error("active duty changed without interrupt");

  duty_rd_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == `OFS_DUTY_HI) |=> (rdata_o == $past(duty_active_r[15:8])))
    else $error("duty read did not return active stage");

  run_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!run && !wr_i) |=> $stable(output_flipflop_r))
    else $error("stopped output did not hold");

  // ---------------------------------------------
  // assertions on interrupt, compare, clock, duty load and read path
  // ---------------------------------------------
  // ticks are two or more cycles apart outside the full tap, and overflow there clears the count, so the pulse never doubles
  irq_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    combined_timer_irq_o |=> !combined_timer_irq_o)
    else $error("interrupt pulse longer than one cycle");

  irq_src_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    combined_timer_irq_o |-> $past(cmp_hit || ovf_hit))
    else $error("interrupt without match or overflow");

  cmp_imm_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == `OFS_CMP_LO) |=> (compare[7:0] == $past(wdata_i)))
    else $error("compare low byte did not act at once");

  cmp_imm_hi_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == `OFS_CMP_HI) |=> (compare[15:8] == $past(wdata_i)))
    else $error("compare high byte did not act at once");

  ev_count_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (run && !wr_i && mode == cascaded_timer_pkg::MODE_EVENT && cksel == `CK_EVENT
     && ev_prev_r && !ev_sync_r[1] && !cmp_hit) |=> (count_r == $past(count_r) + 16'h0001))
    else $error("event falling edge not counted");

  ev_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (mode == cascaded_timer_pkg::MODE_TIMER && cksel == `CK_EVENT) |-> !tick)
    else $error("event input clocked the timer mode");

  full_tick_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (mode == cascaded_timer_pkg::MODE_PWM && cksel == `CK_FULL) |-> tick)
    else $error("full clock tap missing in pwm");

  stop_duty_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !run |=> (duty_active_r == $past({duty_high_byte_r, duty_low_byte_r})))
    else $error("stopped duty not loaded at once");

  rd_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data not zero outside read");

endmodule : cascaded_16bit_timer_pwm

// ===== event_source.sv
// model of the external event source feeding the timer's event input
`timescale 1ns/10ps

module event_source (
  input wire logic clk_i, // system clock
  output logic ev_o // event line, idles high
);
  initial ev_o = 1'b1;

  // low level held four cycles and high at least four, twice the minimum width, so no edge is lost
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      ev_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulse
endmodule : event_source

// ===== cascaded_16bit_timer_pwm_tb_top.sv
// self-checking bench of the cascaded 16-bit timer, event counter and pwm
`timescale 1ns/10ps
`include "cascaded_timer_defs.svh"

module cascaded_16bit_timer_pwm_tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [`ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic ev;
  logic pin;
  logic irq;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_irq = 0;
  int t_irq = 0;
  int t0;
  logic [15:0] v;
  logic [2:0] sel [5] = '{`CK_SLOW_TAP, `CK_DIV7, `CK_DIV5, `CK_DIV3, `CK_LOWFREQ};
  int per [5] = '{2048, 128, 32, 8, 16};
  logic fs = 1'b0;
  logic [2:0] fsc = 3'h0;

  always #5 clk_i = ~clk_i;

  // slow clock stand-in, one rising edge every 16 cycles
  always @(posedge clk_i) begin
    fsc <= fsc + 3'h1;
    if (fsc == 3'h7) begin
      fs <= ~fs;
    end
  end

  cascaded_16bit_timer_pwm uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .low_freq_clock_i(fs),
    .event_input_pin_i(ev), .timer_output_pin_o(pin), .combined_timer_irq_o(irq));
  event_source src (.clk_i(clk_i), .ev_o(ev));

  // ----------------------------------------------------------------
  // bus tasks, checks and monitors
  // ----------------------------------------------------------------
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr8

  // low byte first, then high byte, never one half alone
  task automatic wr16(input logic [2:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(3'(a + 3'h1), d[15:8]);
  endtask : wr16

  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd8

  task automatic rd16(input logic [2:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(3'(a + 3'h1), d[15:8]);
  endtask : rd16

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_irq(input int lim);
    int n0;
    int k;
    n0 = n_irq;
    k = 0;
    while (n_irq == n0 && k < lim) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_irq

  task automatic wait_pin(input logic lvl, input int lim);
    int k;
    k = 0;
    while (pin !== lvl && k < lim) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_pin

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // irq is a one-cycle pulse, sampled mid-cycle so it is never missed
  always @(negedge clk_i) begin
    if (irq === 1'b1) begin
      n_irq++;
      t_irq = cyc;
    end
  end

  // ceiling sits above the longest pwm period plus the tap sweep
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd16(`OFS_CMP_LO, v);
    chk(v, 16'hFFFF);
    chk({15'h0, pin}, 16'h0001);
    $display("reset test done");
    // timer mode: compare 1 gives two ticks between interrupts
    wr16(`OFS_CMP_LO, 16'h0001);
    foreach (sel[i]) begin
      wr8(`OFS_LOWER_CTRL, {5'h00, sel[i]});
      wr8(`OFS_UPPER_CTRL, 8'h08);
      wait_irq(5000);
      t0 = t_irq;
      wait_irq(5000);
      chk(16'(t_irq - t0), 16'(2 * per[i]));
      chk({15'h0, pin}, 16'h0001);
      wr8(`OFS_UPPER_CTRL, 8'h00);
    end
    t0 = n_irq;
    repeat (300) @(posedge clk_i);
    chk(16'(n_irq - t0), 16'h0000);
    $display("timer test done");
    // event mode: third falling edge meets compare 2
    wr16(`OFS_CMP_LO, 16'h0002);
    wr8(`OFS_LOWER_CTRL, {5'h00, `CK_EVENT});
    wr8(`OFS_UPPER_CTRL, 8'h09);
    t0 = n_irq;
    src.pulse(3);
    repeat (8) @(posedge clk_i);
    chk(16'(n_irq - t0), 16'h0001);
    src.pulse(2);
    repeat (8) @(posedge clk_i);
    rd16(`OFS_CNT_LO, v);
    chk(v, 16'h0002);
    $display("event test done");
    // pwm at full clock, duty 0x0100
    wr8(`OFS_UPPER_CTRL, 8'h02);
    wr8(`OFS_LOWER_CTRL, {5'h00, `CK_FULL});
    wr16(`OFS_DUTY_LO, 16'h0100);
    rd16(`OFS_DUTY_LO, v);
    chk(v, 16'h0100);
    wr8(`OFS_UPPER_CTRL, 8'h0A);
    t0 = cyc;
    wait_pin(1'b0, 400);
    chk({15'h0, (cyc - t0) >= 250 && (cyc - t0) <= 262}, 16'h0001);
    wait_irq(70000);
    chk({15'h0, pin}, 16'h0001);
    wr16(`OFS_DUTY_LO, 16'h0200);
    rd16(`OFS_DUTY_LO, v);
    chk(v, 16'h0100);
    wait_pin(1'b0, 400);
    wr8(`OFS_UPPER_CTRL, 8'h02);
    repeat (20) @(posedge clk_i);
    chk({15'h0, pin}, 16'h0000);
    rd16(`OFS_DUTY_LO, v);
    chk(v, 16'h0200);
    wr8(`OFS_UPPER_CTRL, 8'h02);
    #1 chk({15'h0, pin}, 16'h0001);
    wr8(`OFS_UPPER_CTRL, 8'h82);
    #1 chk({15'h0, pin}, 16'h0000);
    $display("pwm test done");
    wrap_up();
  end
endmodule : cascaded_16bit_timer_pwm_tb_top
